// *** core/standby_mode_controller.v ***
// Standby controller: HALT gates the CPU clock, STOP halts the main
// oscillator, and a selectable stabilization wait follows STOP release.
// Assumes the CPU core gives one-cycle instruction pulses and byte writes
// on the same clock; interrupt and oscillator inputs come from outside.
`timescale 1ns/1ps
`include "standby_map.vh"
module standby_mode_controller (
   input wire ref_clk_i, // Main system clock, 100 MHz.
   input wire rst_b_i, // Asynchronous reset, active low.
   input wire halt_exec_i, // Pulse: HALT instruction executed.
   input wire stop_exec_i, // Pulse: STOP instruction executed.
   input wire on_subclock_i, // CPU runs from the subsystem clock.
   input wire main_osc_off_i, // Main oscillator stopped by clock select.
   input wire irq_pending_i, // Unmasked interrupt request pending (pin).
   input wire nmi_i, // Non-maskable interrupt request (pin).
   input wire test_i, // Unmasked test input (pin).
   input wire irq_ack_en_i, // Interrupt acknowledge enabled.
   input wire osc_running_i, // Main oscillator has started (pin).
   input wire timer_ext_input_a_i, // 8-bit timer A counts external input.
   input wire timer_ext_input_b_i, // 8-bit timer B counts external input.
   input wire [15:0] reg_addr_i, // Register address.
   input wire reg_wr_i, // Byte write strobe.
   input wire reg_rd_i, // Byte read strobe.
   input wire reg_bit_wr_i, // Single-bit write strobe.
   input wire [7:0] reg_wdata_i, // Write data.
   output reg [7:0] reg_rdata_o, // Read data.
   output wire cpu_clk_en_o, // CPU clock gate enable.
   output wire main_osc_en_o, // Main oscillator enable.
   output wire sub_osc_en_o, // Subsystem oscillator enable.
   output wire hold_state_o, // Freeze registers, memory and ports.
   output reg wake_vector_o, // Pulse: take interrupt vector on wake.
   output reg wake_next_o, // Pulse: resume at next instruction.
   output wire timer_a_run_o, // Run enable for 8-bit timer A.
   output wire timer_b_run_o, // Run enable for 8-bit timer B.
   output wire [1:0] mode_o // 0 run, 1 halt, 2 stop, 3 wait.
);
   // This block runs on a free-running reference clock and keeps counting through
   // STOP; in silicon only the release logic would stay awake while the oscillator
   // is down, so the restart flag, not this clock, decides when the wait may begin.
   // Mode codes, also shown on mode_o.
   localparam ST_RUN = 2'h0;
   localparam ST_HALT = 2'h1;
   localparam ST_STOP = 2'h2;
   localparam ST_WAIT = 2'h3;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [7:0] stab_sel_q;
   reg [2:0] irq_s1_q, irq_s2_q;
   reg osc_s1_q, osc_s2_q, osc_seen_q;
   reg release_q;
   reg start_wait;
   reg halt_from_stop_q;
   wire irq_sync, nmi_sync, test_sync, osc_sync;
   wire wake_src;
   wire run_entry;
   wire vector_wake;
   wire timer_gate;
   wire wait_busy;
   wire wait_done;
   wire [`STAB_CNT_WIDTH-1:0] terminal;

   // Maps a select code to its terminal count of 2^n - 1 periods.
   function [`STAB_CNT_WIDTH-1:0] stab_terminal;
      input [2:0] code;
      reg [4:0] expo;
      begin
         case (code)
            `STAB_CODE_2E13: expo = `STAB_EXP_2E13;
            `STAB_CODE_2E15: expo = `STAB_EXP_2E15;
            `STAB_CODE_2E16: expo = `STAB_EXP_2E16;
            `STAB_CODE_2E17: expo = `STAB_EXP_2E17;
            default: expo = `STAB_EXP_2E18; // Prohibited codes take the longest wait, the safe side.
         endcase
         stab_terminal = ({{(`STAB_CNT_WIDTH-1){1'b0}}, 1'b1} << expo) - {{(`STAB_CNT_WIDTH-1){1'b0}}, 1'b1};
      end
   endfunction

   // Two-flop synchronisers for the pin-level wake sources and oscillator flag.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_s1_q <= 3'h0;
         irq_s2_q <= 3'h0;
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
      end else begin
         irq_s1_q <= {test_i, nmi_i, irq_pending_i};
         irq_s2_q <= irq_s1_q;
         osc_s1_q <= osc_running_i;
         osc_s2_q <= osc_s1_q;
      end
   end
   assign irq_sync = irq_s2_q[0];
   assign nmi_sync = irq_s2_q[1];
   assign test_sync = irq_s2_q[2];
   assign osc_sync = osc_s2_q;
   assign wake_src = irq_sync | nmi_sync | test_sync;

   // Select register: whole-byte writes only; bit writes are ignored.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stab_sel_q <= `STAB_SEL_RESET;
      end else if (reg_wr_i && !reg_bit_wr_i && reg_addr_i == `STAB_SEL_ADDR) begin
         stab_sel_q <= {5'h00, reg_wdata_i[`STAB_SEL_MSB:`STAB_SEL_LSB]};
      end
   end

   // Read port: registered data, zero off the map.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= (reg_addr_i == `STAB_SEL_ADDR) ? stab_sel_q : 8'h00;
      end
   end

   // The terminal follows the select register live, so a write during a wait changes its length.
   assign terminal = stab_terminal(stab_sel_q[`STAB_SEL_MSB:`STAB_SEL_LSB]);

   // Return to run from any standby mode; NMI always vectors, a maskable request only with acknowledge on.
   assign run_entry = (state_q != ST_RUN) && (state_d == ST_RUN);
   assign vector_wake = nmi_sync || (irq_sync && irq_ack_en_i);

   // Mode sequencing.
   always @* begin
      state_d = state_q;
      start_wait = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (stop_exec_i && !on_subclock_i) begin
               if (irq_sync) state_d = ST_HALT;
               else state_d = ST_STOP;
            end else if (halt_exec_i) begin
               state_d = ST_HALT;
            end
         end
         ST_HALT: begin
            if (halt_from_stop_q) begin
               if (osc_sync) begin
                  state_d = ST_WAIT;
                  start_wait = 1'b1;
               end
            end else if (wake_src) begin
               state_d = ST_RUN;
            end
         end
         ST_STOP: begin
            if (osc_seen_q) begin
               state_d = ST_WAIT;
               start_wait = 1'b1;
            end
         end
         ST_WAIT: begin
            if (wait_done) state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
   end

   // State register, STOP-origin flag and oscillator restart tracking.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_RUN;
         halt_from_stop_q <= 1'b0;
         osc_seen_q <= 1'b0;
         release_q <= 1'b0;
         wake_vector_o <= 1'b0;
         wake_next_o <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_RUN) halt_from_stop_q <= stop_exec_i && !on_subclock_i && irq_sync;
         // The release is latched, so a short request still ends STOP once the oscillator is back.
         if (state_q != ST_STOP) release_q <= 1'b0;
         else if (irq_sync) release_q <= 1'b1;
         // The oscillator drops in STOP; only a fresh start after release may begin the count.
         if (state_q != ST_STOP) osc_seen_q <= 1'b0;
         else if (release_q && osc_sync) osc_seen_q <= 1'b1;
         wake_vector_o <= run_entry && vector_wake;
         wake_next_o <= run_entry && !vector_wake;
      end
   end

   stab_wait_counter #(
      .CNT_WIDTH(`STAB_CNT_WIDTH)
   ) u_wait (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .start_i(start_wait),
      .terminal_i(terminal),
      .busy_o(wait_busy),
      .done_o(wait_done)
   );

   // Clock gating and hold outputs; the subclock oscillator always runs.
   // The main oscillator comes back on as soon as a release is latched in STOP,
   // since the wait cannot begin before the oscillator has really started again.
   assign cpu_clk_en_o = (state_q == ST_RUN) && !wait_busy;
   assign main_osc_en_o = (state_q != ST_STOP) || release_q;
   assign sub_osc_en_o = 1'b1;
   assign hold_state_o = (state_q != ST_RUN);
   // Timers on the internal clock stop in subclock HALT with the main oscillator off.
   assign timer_gate = (state_q == ST_HALT) && on_subclock_i && main_osc_off_i;
   assign timer_a_run_o = !timer_gate || timer_ext_input_a_i;
   assign timer_b_run_o = !timer_gate || timer_ext_input_b_i;
   assign mode_o = state_q;
endmodule // standby_mode_controller

// *** core/standby_map.vh ***
// Constants for the standby mode controller: register offset, reset value,
// stabilization code table and field positions.
// Assumes the includer works with an 8-bit data path and a 16-bit address.
`ifndef STANDBY_MAP_VH
`define STANDBY_MAP_VH
`define STAB_SEL_ADDR 16'hfffa
`define STAB_SEL_RESET 8'h04
`define STAB_SEL_LSB 0
`define STAB_SEL_MSB 2
`define STAB_CODE_2E13 3'h0
`define STAB_CODE_2E15 3'h1
`define STAB_CODE_2E16 3'h2
`define STAB_CODE_2E17 3'h3
`define STAB_CODE_2E18 3'h4
`define STAB_EXP_2E13 5'h0d
`define STAB_EXP_2E15 5'h0f
`define STAB_EXP_2E16 5'h10
`define STAB_EXP_2E17 5'h11
`define STAB_EXP_2E18 5'h12
`define STAB_CNT_WIDTH 19
`endif

// *** core/stab_wait_counter.v ***
// Oscillation stabilization wait counter, clocked by the main system clock.
// Assumes start_i is a one-cycle pulse given once the oscillator runs again.
`timescale 1ns/1ps
`include "standby_map.vh"
module stab_wait_counter #(
   parameter CNT_WIDTH = `STAB_CNT_WIDTH
) (
   input wire ref_clk_i, // Main system clock.
   input wire rst_b_i, // Asynchronous reset, active low.
   input wire start_i, // Pulse: begin a new wait.
   input wire [CNT_WIDTH-1:0] terminal_i, // Last count value of the wait.
   output wire busy_o, // High while the wait runs.
   output reg done_o // One-cycle pulse when the wait ends.
);
   reg [CNT_WIDTH-1:0] count_q;
   reg busy_q;

   assign busy_o = busy_q;

   // Counts main clock periods up to the terminal value, then fires done.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_q <= {CNT_WIDTH{1'b0}};
         busy_q <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            count_q <= {CNT_WIDTH{1'b0}};
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (count_q == terminal_i) begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
            end else begin
               count_q <= count_q + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // stab_wait_counter

// *** sim/standby_asserts.sv ***
// Checker for the standby controller's mode, gating and oscillator outputs.
// Assumes a single clock domain and the controller's 2-bit mode encoding.
`timescale 1ns/1ps
module standby_asserts (
   input wire ref_clk_i, // Clock.
   input wire rst_b_i, // Reset, active low.
   input wire halt_exec_i, // Halt pulse.
   input wire stop_exec_i, // Stop pulse.
   input wire on_subclock_i, // Subclock level.
   input wire cpu_clk_en_o, // CPU gate.
   input wire main_osc_en_o, // Main oscillator.
   input wire sub_osc_en_o, // Subclock oscillator.
   input wire hold_state_o, // State freeze.
   input wire [1:0] mode_o // Mode.
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Entries are checked one edge after the pulse; the wait is never shorter than 8 cycles.
   AST_HALT_IN: assert property (mode_o == 2'h0 && halt_exec_i && !stop_exec_i |=> mode_o == 2'h1 && main_osc_en_o)
      else $error("halt entry wrong");
   AST_STOP_IN: assert property (mode_o == 2'h0 && stop_exec_i && !halt_exec_i && !on_subclock_i |=> mode_o inside {2'h1, 2'h2})
      else $error("stop entry wrong");
   AST_STOP_SUB: assert property (mode_o == 2'h0 && stop_exec_i && !halt_exec_i && on_subclock_i |=> mode_o == 2'h0)
      else $error("stop taken on subclock");
   AST_SUB_OSC: assert property (sub_osc_en_o)
      else $error("subclock oscillator stopped");
   AST_HOLD: assert property (hold_state_o == (mode_o != 2'h0))
      else $error("hold state wrong");
   AST_GATE: assert property (cpu_clk_en_o == (mode_o == 2'h0))
      else $error("cpu gate wrong");
   AST_OSC_OFF: assert property (mode_o != 2'h2 |-> main_osc_en_o)
      else $error("main oscillator off outside stop");
   AST_STOP_OSC: assert property ($rose(mode_o == 2'h2) |-> !main_osc_en_o)
      else $error("main oscillator left on at stop entry");
   AST_WAIT_END: assert property (mode_o == 2'h3 ##1 mode_o != 2'h3 |-> mode_o == 2'h0)
      else $error("wait left to wrong mode");
   AST_WAIT_LEN: assert property ($rose(mode_o == 2'h3) |-> (mode_o == 2'h3) [*8])
      else $error("wait too short");
   cover property (mode_o == 2'h1);
   cover property (mode_o == 2'h2);
   cover property (mode_o == 2'h3 ##1 mode_o == 2'h0);
   cover property (mode_o == 2'h1 ##1 mode_o == 2'h3);
endmodule // standby_asserts
bind standby_mode_controller standby_asserts chk_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
   .halt_exec_i(halt_exec_i), .stop_exec_i(stop_exec_i), .on_subclock_i(on_subclock_i),
   .cpu_clk_en_o(cpu_clk_en_o), .main_osc_en_o(main_osc_en_o), .sub_osc_en_o(sub_osc_en_o),
   .hold_state_o(hold_state_o), .mode_o(mode_o));

// *** sim/tb.sv ***
// Testbench for the standby controller: register, HALT and STOP scenarios.
// Assumes the controller alone; the bench drives every input at falling edges.
`timescale 1ns/1ps
module tb;
   reg ref_clk_i = 0, rst_b_i = 0, hx = 0, sx = 0, sub = 0, moff = 0, irq = 0, nmi = 0, tst = 0;
   reg ack = 0, osc = 0, xa = 0, xb = 0, wr = 0, rd = 0, bw = 0, v, w;
   reg [15:0] addr = 16'h0000;
   reg [7:0] wd = 8'h00;
   wire [7:0] rdata;
   wire cen, oen, sen, hold, wv, wn, tra, trb;
   wire [1:0] mode;
   integer err_count = 0, samples_checked = 0, n;
   // Clock of 10 ns.
   always #5 ref_clk_i = ~ref_clk_i;
   standby_mode_controller dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .halt_exec_i(hx), .stop_exec_i(sx),
      .on_subclock_i(sub), .main_osc_off_i(moff), .irq_pending_i(irq), .nmi_i(nmi), .test_i(tst),
      .irq_ack_en_i(ack), .osc_running_i(osc), .timer_ext_input_a_i(xa), .timer_ext_input_b_i(xb),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_bit_wr_i(bw), .reg_wdata_i(wd),
      .reg_rdata_o(rdata), .cpu_clk_en_o(cen), .main_osc_en_o(oen), .sub_osc_en_o(sen),
      .hold_state_o(hold), .wake_vector_o(wv), .wake_next_o(wn), .timer_a_run_o(tra),
      .timer_b_run_o(trb), .mode_o(mode));
   // Compares with case equality so an unknown never matches.
   task chk(input [7:0] s, input [7:0] e);
      begin
         samples_checked++;
         if (s !== e) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   task wrb(input [7:0] d, input b);
      begin
         @(negedge ref_clk_i) addr = 16'hfffa;
         wd = d; wr = 1; bw = b;
         @(negedge ref_clk_i) wr = 0;
         bw = 0;
      end
   endtask
   // Read data is registered at the taking edge, so it is settled at the next falling edge.
   task rdb(input [15:0] a, input [7:0] e);
      begin
         @(negedge ref_clk_i) addr = a;
         rd = 1;
         @(negedge ref_clk_i) rd = 0;
         chk(rdata, e);
      end
   endtask
   task pulse(input h);
      begin
         @(negedge ref_clk_i) hx = h;
         sx = !h;
         @(negedge ref_clk_i) hx = 0;
         sx = 0;
      end
   endtask
   // Bounded wait for a mode; the wake pulses are sampled with the mode and again one cycle later.
   task wm(input [1:0] m, input integer lim);
      begin
         n = 0;
         while (mode !== m && n < lim) begin
            @(negedge ref_clk_i);
            n++;
         end
         chk(mode, m);
         v = wv; w = wn;
         @(negedge ref_clk_i) v = v | wv;
         w = w | wn;
      end
   endtask
   task t_regs;
      begin
         rdb(16'hfffa, 8'h04);
         wrb(8'h03, 1);
         rdb(16'hfffa, 8'h04);
         wrb(8'hff, 0);
         rdb(16'hfffa, 8'h07);
         rdb(16'hfff8, 8'h00);
      end
   endtask
   task t_halt;
      begin
         ack = 1;
         pulse(1);
         chk({cen, oen, hold, mode}, 8'h0d);
         irq = 1;
         wm(2'h0, 4);
         chk({v, w}, 8'h02);
         irq = 0; sub = 1; moff = 1; xa = 1;
         repeat (3) @(negedge ref_clk_i);
         pulse(1);
         chk({tra, trb, mode}, 8'h09);
         tst = 1;
         wm(2'h0, 4);
         chk({v, w}, 8'h01);
         pulse(0);
         chk({sen, mode}, 8'h04);
         tst = 0; sub = 0; moff = 0; xa = 0;
      end
   endtask
   task t_stop(input [2:0] c, input integer e);
      begin
         wrb({5'h00, c}, 0);
         pulse(0);
         chk({cen, oen, mode}, 8'h02);
         irq = 1;
         repeat (6) @(negedge ref_clk_i);
         chk(mode, 2'h2);
         chk(oen, 8'h01);
         osc = 1;
         wm(2'h3, 6);
         wm(2'h0, e + 50);
         chk(n + 1 >= e - 2 && n + 1 <= e + 4, 1);
         chk({v, w}, 8'h02);
         rdb(16'hfffa, {5'h00, c});
         irq = 0; osc = 0;
      end
   endtask
   task t_pend;
      begin
         irq = 1;
         wrb(8'h00, 0);
         pulse(0);
         chk(mode, 2'h1);
         osc = 1;
         wm(2'h3, 6);
         wm(2'h0, 8250);
         irq = 0; osc = 0;
      end
   endtask
   // NMI wakes HALT with a vector even with acknowledge off; a maskable request then resumes.
   task t_nmi;
      begin
         ack = 0;
         pulse(1);
         nmi = 1;
         wm(2'h0, 4);
         chk({v, w}, 8'h02);
         nmi = 0;
         repeat (3) @(negedge ref_clk_i);
         pulse(1);
         irq = 1;
         wm(2'h0, 4);
         chk({v, w}, 8'h01);
         irq = 0; ack = 1;
         repeat (3) @(negedge ref_clk_i);
      end
   endtask
   // Reset in mid-run from HALT must restore run mode and the select register.
   task t_rst;
      begin
         wrb(8'h01, 0);
         pulse(1);
         @(negedge ref_clk_i) rst_b_i = 0;
         @(negedge ref_clk_i) chk({cen, oen, hold, mode}, 8'h18);
         repeat (2) @(negedge ref_clk_i);
         rst_b_i = 1;
         rdb(16'hfffa, 8'h04);
      end
   endtask
   task wrap_up;
      begin
         $display("errors %0d checks %0d", err_count, samples_checked);
         if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // Watchdog at 70000 cycles, well beyond the roughly 50000 cycles of the tests.
   initial begin
      #700000;
      err_count++;
      wrap_up;
   end
   initial begin
      repeat (10) @(negedge ref_clk_i);
      rst_b_i = 1;
      t_regs;
      t_halt;
      t_nmi;
      t_stop(3'h0, 8192);
      t_stop(3'h1, 32768);
      t_pend;
      t_rst;
      wrap_up;
   end
endmodule // tb
